// ==== etm_edge_timing.sv ====
// Edge time measurement unit with APB register access
//
// Summary of operation
// (R1) Continuous mode measures every edge of the channel without arming.
// (R2) Config bits 8-11 pick which start-edge history entry is the reference.
// (R3) Config bits 12-15 pick resolution: 8,4,2,1 MHz, 500,250,125,62.5 kHz.
// (R4) Triggered mode measures rising edges only after the rising arm bit is set.
// (R5) Writing falling arm 1 arms for the next falling edge; 0 means none.
// (R6) Writing rising arm 1 arms for the next rising edge; 0 withdraws it.
// (R7) Arm and pending bits pack channels 1-8 and 9-15; top bit reserved.
// (R8) Falling pending stays 1 while waiting, clears on a falling edge.
// (R9) Rising pending stays 1 while waiting, clears on a rising edge.
// (R10) Each channel counts falling edges in an 8-bit wrapping tally.
// (R11) Each channel counts rising edges in an 8-bit wrapping tally.
// (R12) A falling edge copies the module timer into the falling stamp.
// (R13) A rising edge copies the module timer into the rising stamp.
// (R14) A falling edge stores time since the start edge in falling delta.
// (R15) A rising edge stores time since the start edge in rising delta.
// (R16) Controller must not run bus cycles shorter than 150 us.
// (R17) Controller keeps cycles of 150 us or longer for every-cycle refresh.
// (R18) Global enable bit 0 switches all measurement off or on.
// (R19) Config bits 0-3 pick the start-edge channel, 0 for 1 up to 14 for 15.
// (R20) Config bit 4 picks start polarity: 0 falling, 1 rising.
// (R21) History keeps 16 newest start stamps; deltas wrap modulo 65536.
// (R22) Unarmed triggered channels keep stamp, delta and tally unchanged.
`timescale 1ns/1ns
`default_nettype none

module etm_edge_timing
(
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [etm_pkg::NUM_CH-1:0] pinIn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr
);
  import etm_pkg::*;

  // Resolution scaling of a base timer value into a 16-bit count
  function automatic logic [STAMP_W-1:0] scaleTime(input logic [BASE_W-1:0] t,
                                                   input logic [3:0] res);
    logic [2:0]        shift;
    logic [BASE_W-1:0] shifted;
    shift   = (res > 4'(RES_MAX)) ? 3'(RES_MAX) : res[2:0];
    shifted = t >> shift;
    return shifted[STAMP_W-1:0];
  endfunction

  // Module timer
  logic [4:0]              tickAcc;
  logic [4:0]              next_tickAcc;
  logic                    tick;
  logic [BASE_W-1:0]       baseTime;

  // Software state
  logic                    globalEnable;
  logic [NUM_CH-1:0]       fallArm;
  logic [NUM_CH-1:0]       riseArm;
  logic [NUM_CH-1:0]       fallPend;
  logic [NUM_CH-1:0]       risePend;
  logic [15:0]             fallCfg   [NUM_CH];
  logic [15:0]             riseCfg   [NUM_CH];
  logic [7:0]              fallTally [NUM_CH];
  logic [7:0]              riseTally [NUM_CH];
  logic [STAMP_W-1:0]      fallStamp [NUM_CH];
  logic [STAMP_W-1:0]      riseStamp [NUM_CH];
  logic [STAMP_W-1:0]      fallDelta [NUM_CH];
  logic [STAMP_W-1:0]      riseDelta [NUM_CH];

  // Edges and start histories; sources 0-14 falling, 15-29 rising
  logic [NUM_CH-1:0]       riseEdge;
  logic [NUM_CH-1:0]       fallEdge;
  logic [NUM_SRC-1:0]      srcPush;
  logic [FIFO_DEPTH-1:0][BASE_W-1:0] history [NUM_SRC];

  // APB decode
  logic                    setupPhase;
  logic                    accessDone;
  logic                    wrDone;
  logic [3:0]              wordIdx;
  logic [5:0]              group;
  logic                    idxValid;
  logic                    hitMisc;
  logic                    hitFallCfg;
  logic                    hitRiseCfg;
  logic                    hitFallTally;
  logic                    hitRiseTally;
  logic                    hitFallStamp;
  logic                    hitRiseStamp;
  logic                    hitFallDelta;
  logic                    hitRiseDelta;
  logic                    miscValid;
  logic                    mapped;
  logic                    wrEnable;
  logic                    wrFallArmLo;
  logic                    wrFallArmHi;
  logic                    wrRiseArmLo;
  logic                    wrRiseArmHi;
  logic [NUM_CH-1:0]       fallArmWrite;
  logic [NUM_CH-1:0]       riseArmWrite;
  logic [NUM_CH-1:0]       next_fallArm;
  logic [NUM_CH-1:0]       next_riseArm;
  logic [15:0]             fallArmFull;
  logic [15:0]             riseArmFull;
  logic [15:0]             fallPendFull;
  logic [15:0]             risePendFull;
  logic [31:0]             miscData;
  logic [31:0]             chanData;
  logic [31:0]             next_prdata;

  // Fractional tick at the 8 MHz base rate from the 100 MHz clock
  assign next_tickAcc = (tickAcc + TICK_STEP >= TICK_MOD)
                        ? 5'(tickAcc + TICK_STEP - TICK_MOD) : 5'(tickAcc + TICK_STEP);
  assign tick         = (tickAcc + TICK_STEP >= TICK_MOD);

  // Free-running base timer, wide enough for the coarsest resolution
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickAcc  <= 5'h00;
      baseTime <= '0;
    end
    else
    begin
      tickAcc <= next_tickAcc;
      if (tick)
        baseTime <= baseTime + 1'b1;
    end
  end

  etm_edge_sync u_sync
  (
    .clk      (clk),
    .rstn     (rstn),
    .pinIn    (pinIn),
    .riseEdge (riseEdge),
    .fallEdge (fallEdge)
  );

  // Start-edge histories, filled only while the function is enabled
  assign srcPush = globalEnable ? {riseEdge, fallEdge} : '0;  // R18

  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++)
    begin : g_hist
      etm_start_history u_hist
      (
        .clk     (clk),
        .rstn    (rstn),
        .push    (srcPush[s]),  // R21
        .stampIn (baseTime),
        .entry   (history[s])
      );
    end
  endgenerate

  // Bus phases; zero wait states, answer prepared in the setup cycle
  assign setupPhase = psel && !penable && !pready;
  assign accessDone = psel && penable && pready;
  assign wrDone     = accessDone && pwrite;
  assign wordIdx    = paddr[5:2];
  assign group      = paddr[11:6];
  assign idxValid   = (wordIdx < 4'(NUM_CH));

  assign hitMisc      = (group == OFS_MISC[11:6]);
  assign hitFallCfg   = (group == OFS_FALL_CFG[11:6]) && idxValid;
  assign hitRiseCfg   = (group == OFS_RISE_CFG[11:6]) && idxValid;
  assign hitFallTally = (group == OFS_FALL_TALLY[11:6]) && idxValid;
  assign hitRiseTally = (group == OFS_RISE_TALLY[11:6]) && idxValid;
  assign hitFallStamp = (group == OFS_FALL_STAMP[11:6]) && idxValid;
  assign hitRiseStamp = (group == OFS_RISE_STAMP[11:6]) && idxValid;
  assign hitFallDelta = (group == OFS_FALL_DELTA[11:6]) && idxValid;
  assign hitRiseDelta = (group == OFS_RISE_DELTA[11:6]) && idxValid;
  assign miscValid    = hitMisc && (wordIdx <= IDX_RISE_PEND_HI);
  assign mapped       = miscValid || hitFallCfg || hitRiseCfg || hitFallTally
                        || hitRiseTally || hitFallStamp || hitRiseStamp
                        || hitFallDelta || hitRiseDelta;

  // Write strobes for the control registers
  assign wrEnable    = wrDone && hitMisc && (wordIdx == IDX_GLOBAL_ENABLE);
  assign wrFallArmLo = wrDone && hitMisc && (wordIdx == IDX_FALL_ARM_LO);
  assign wrFallArmHi = wrDone && hitMisc && (wordIdx == IDX_FALL_ARM_HI);
  assign wrRiseArmLo = wrDone && hitMisc && (wordIdx == IDX_RISE_ARM_LO);
  assign wrRiseArmHi = wrDone && hitMisc && (wordIdx == IDX_RISE_ARM_HI);

  // Arm bits split into a low byte for channels 1-8, high byte for 9-15
  assign fallArmWrite = {{7{wrFallArmHi}}, {8{wrFallArmLo}}};  // R7
  assign riseArmWrite = {{7{wrRiseArmHi}}, {8{wrRiseArmLo}}};  // R7
  assign next_fallArm = wrFallArmHi ? {pwdata[6:0], fallArm[7:0]}
                      : wrFallArmLo ? {fallArm[14:8], pwdata[7:0]} : fallArm;
  assign next_riseArm = wrRiseArmHi ? {pwdata[6:0], riseArm[7:0]}
                      : wrRiseArmLo ? {riseArm[14:8], pwdata[7:0]} : riseArm;

  // Global enable and arm registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      globalEnable <= 1'b0;
      fallArm      <= '0;
      riseArm      <= '0;
    end
    else
    begin
      if (wrEnable)
        globalEnable <= pwdata[0];  // R18
      fallArm <= next_fallArm;  // R5
      riseArm <= next_riseArm;  // R6
    end
  end

  // Per-channel configuration, pending flags, tallies, stamps and deltas
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic              fallCont;
      logic              riseCont;
      logic              fallHit;
      logic              riseHit;
      logic [3:0]        fallSrcCh;
      logic [3:0]        riseSrcCh;
      logic [4:0]        fallSrc;
      logic [4:0]        riseSrc;
      logic [BASE_W-1:0] fallStart;
      logic [BASE_W-1:0] riseStart;
      logic              fallArmSet;
      logic              riseArmSet;
      logic              fallArmClr;
      logic              riseArmClr;

      assign fallCont = fallCfg[c][CFG_CONTINUOUS];
      assign riseCont = riseCfg[c][CFG_CONTINUOUS];

      // Qualified edges: continuous always, triggered only while waiting
      assign fallHit = globalEnable && fallEdge[c] && (fallCont || fallPend[c]);  // R1 R22
      assign riseHit = globalEnable && riseEdge[c] && (riseCont || risePend[c]);  // R1 R4

      // Start source: channel from bits 0-3, polarity from bit 4
      assign fallSrcCh = fallCfg[c][CFG_SRC_CH_LSB +: 4];  // R19
      assign riseSrcCh = riseCfg[c][CFG_SRC_CH_LSB +: 4];  // R19
      assign fallSrc   = fallCfg[c][CFG_SRC_EDGE] ? (5'(fallSrcCh) + 5'(NUM_CH))
                                                  : 5'(fallSrcCh);  // R20
      assign riseSrc   = riseCfg[c][CFG_SRC_EDGE] ? (5'(riseSrcCh) + 5'(NUM_CH))
                                                  : 5'(riseSrcCh);  // R20

      // Reference entry picked by bits 8-11, channel code 15 has no source
      assign fallStart = (fallSrcCh < 4'(NUM_CH))
                         ? history[fallSrc][fallCfg[c][CFG_ENTRY_LSB +: 4]] : '0;  // R2
      assign riseStart = (riseSrcCh < 4'(NUM_CH))
                         ? history[riseSrc][riseCfg[c][CFG_ENTRY_LSB +: 4]] : '0;  // R2

      // Arm writes: a one arms, a zero withdraws
      assign fallArmSet = fallArmWrite[c] && next_fallArm[c];
      assign riseArmSet = riseArmWrite[c] && next_riseArm[c];
      assign fallArmClr = fallArmWrite[c] && !next_fallArm[c];
      assign riseArmClr = riseArmWrite[c] && !next_riseArm[c];

      // Pending flags; an arming write wins over an edge in the same cycle
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          fallPend[c] <= 1'b0;
          risePend[c] <= 1'b0;
        end
        else
        begin
          if (fallArmSet)
            fallPend[c] <= 1'b1;  // R5 R8
          else if (fallArmClr || (globalEnable && fallEdge[c]))
            fallPend[c] <= 1'b0;  // R8
          if (riseArmSet)
            risePend[c] <= 1'b1;  // R6 R9
          else if (riseArmClr || (globalEnable && riseEdge[c]))
            risePend[c] <= 1'b0;  // R9
        end
      end

      // Configuration words; reserved bits 5-6 stay zero
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          fallCfg[c] <= CFG_RESET;
          riseCfg[c] <= CFG_RESET;
        end
        else
        begin
          if (wrDone && hitFallCfg && (wordIdx == 4'(c)))
            fallCfg[c] <= pwdata[15:0] & CFG_WRITE_MASK;
          if (wrDone && hitRiseCfg && (wordIdx == 4'(c)))
            riseCfg[c] <= pwdata[15:0] & CFG_WRITE_MASK;
        end
      end

      // Measurement results, updated only on qualified edges
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          fallTally[c] <= TALLY_RESET;
          riseTally[c] <= TALLY_RESET;
          fallStamp[c] <= STAMP_RESET;
          riseStamp[c] <= STAMP_RESET;
          fallDelta[c] <= STAMP_RESET;
          riseDelta[c] <= STAMP_RESET;
        end
        else
        begin
          if (fallHit)
          begin
            fallTally[c] <= fallTally[c] + 8'h01;  // R10
            fallStamp[c] <= scaleTime(baseTime, fallCfg[c][CFG_RES_LSB +: 4]);  // R12 R3
            fallDelta[c] <= scaleTime(baseTime - fallStart,
                                      fallCfg[c][CFG_RES_LSB +: 4]);  // R14 R21
          end
          if (riseHit)
          begin
            riseTally[c] <= riseTally[c] + 8'h01;  // R11
            riseStamp[c] <= scaleTime(baseTime, riseCfg[c][CFG_RES_LSB +: 4]);  // R13 R3
            riseDelta[c] <= scaleTime(baseTime - riseStart,
                                      riseCfg[c][CFG_RES_LSB +: 4]);  // R15 R21
          end
        end
      end
    end
  endgenerate

  // Packed views of arm and pending bits; bit 7 of the high byte reads zero
  assign fallArmFull  = {1'b0, fallArm};  // R7
  assign riseArmFull  = {1'b0, riseArm};  // R7
  assign fallPendFull = {1'b0, fallPend};  // R7
  assign risePendFull = {1'b0, risePend};  // R7

  // Read selection for the miscellaneous group
  assign miscData =
      (wordIdx == IDX_GLOBAL_ENABLE) ? {31'h0, globalEnable}
    : (wordIdx == IDX_FALL_ARM_LO)   ? {24'h0, fallArmFull[7:0]}
    : (wordIdx == IDX_FALL_ARM_HI)   ? {24'h0, fallArmFull[15:8]}
    : (wordIdx == IDX_RISE_ARM_LO)   ? {24'h0, riseArmFull[7:0]}
    : (wordIdx == IDX_RISE_ARM_HI)   ? {24'h0, riseArmFull[15:8]}
    : (wordIdx == IDX_FALL_PEND_LO)  ? {24'h0, fallPendFull[7:0]}
    : (wordIdx == IDX_FALL_PEND_HI)  ? {24'h0, fallPendFull[15:8]}
    : (wordIdx == IDX_RISE_PEND_LO)  ? {24'h0, risePendFull[7:0]}
    : (wordIdx == IDX_RISE_PEND_HI)  ? {24'h0, risePendFull[15:8]}
    : 32'h0000_0000;

  // Read selection for the per-channel groups
  assign chanData =
      hitFallCfg   ? {16'h0, fallCfg[wordIdx]}
    : hitRiseCfg   ? {16'h0, riseCfg[wordIdx]}
    : hitFallTally ? {24'h0, fallTally[wordIdx]}
    : hitRiseTally ? {24'h0, riseTally[wordIdx]}
    : hitFallStamp ? {16'h0, fallStamp[wordIdx]}
    : hitRiseStamp ? {16'h0, riseStamp[wordIdx]}
    : hitFallDelta ? {16'h0, fallDelta[wordIdx]}
    : hitRiseDelta ? {16'h0, riseDelta[wordIdx]}
    : 32'h0000_0000;

  assign next_prdata = miscValid ? miscData : chanData;

  // Bus answer: ready and data registered in the setup cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (setupPhase)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= (!pwrite && mapped) ? next_prdata : 32'h0000_0000;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule // etm_edge_timing

`default_nettype wire

// ==== etm_pkg.sv ====
// Shared constants for the edge time measurement block
package etm_pkg;

  // Channel and field geometry
  localparam int unsigned NUM_CH     = 15;
  localparam int unsigned NUM_SRC    = 2 * NUM_CH;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned STAMP_W    = 16;
  localparam int unsigned RES_MAX    = 7;
  localparam int unsigned BASE_W     = STAMP_W + RES_MAX;

  // Clock rate and base timer rate, ticks made by a fractional accumulator
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned BASE_HZ   = 8_000_000;
  localparam int unsigned RATIO_GCD = 4_000_000;
  localparam logic [4:0] TICK_STEP  = 5'(BASE_HZ / RATIO_GCD);
  localparam logic [4:0] TICK_MOD   = 5'(CLK_HZ / RATIO_GCD);

  // Settle cycles before pin edges are believed after reset
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // Shortest bus cycle the controller may run, in microseconds
  localparam int unsigned MIN_BUS_CYCLE_US = 150;

  // Register groups, each 16 words; byte address = group offset + 4 * index
  localparam logic [11:0] OFS_MISC         = 12'h000;
  localparam logic [11:0] OFS_FALL_CFG     = 12'h040;
  localparam logic [11:0] OFS_RISE_CFG     = 12'h080;
  localparam logic [11:0] OFS_FALL_TALLY   = 12'h0C0;
  localparam logic [11:0] OFS_RISE_TALLY   = 12'h100;
  localparam logic [11:0] OFS_FALL_STAMP   = 12'h140;
  localparam logic [11:0] OFS_RISE_STAMP   = 12'h180;
  localparam logic [11:0] OFS_FALL_DELTA   = 12'h1C0;
  localparam logic [11:0] OFS_RISE_DELTA   = 12'h200;

  // Word indexes inside the miscellaneous group
  localparam logic [3:0] IDX_GLOBAL_ENABLE  = 4'h0;
  localparam logic [3:0] IDX_FALL_ARM_LO    = 4'h1;
  localparam logic [3:0] IDX_FALL_ARM_HI    = 4'h2;
  localparam logic [3:0] IDX_RISE_ARM_LO    = 4'h3;
  localparam logic [3:0] IDX_RISE_ARM_HI    = 4'h4;
  localparam logic [3:0] IDX_FALL_PEND_LO   = 4'h5;
  localparam logic [3:0] IDX_FALL_PEND_HI   = 4'h6;
  localparam logic [3:0] IDX_RISE_PEND_LO   = 4'h7;
  localparam logic [3:0] IDX_RISE_PEND_HI   = 4'h8;

  // Timing config field positions
  localparam int unsigned CFG_SRC_CH_LSB  = 0;
  localparam int unsigned CFG_SRC_EDGE    = 4;
  localparam int unsigned CFG_CONTINUOUS  = 7;
  localparam int unsigned CFG_ENTRY_LSB   = 8;
  localparam int unsigned CFG_RES_LSB     = 12;
  localparam logic [15:0] CFG_WRITE_MASK  = 16'hFF9F;

  // Reset values
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [7:0]  TALLY_RESET = 8'h00;
  localparam logic [15:0] STAMP_RESET = 16'h0000;

endpackage : etm_pkg

// ==== etm_edge_sync.sv ====
// Pin synchroniser and edge detector for all measurement channels
`timescale 1ns/1ns
`default_nettype none

module etm_edge_sync
(
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [etm_pkg::NUM_CH-1:0] pinIn,
  output logic      [etm_pkg::NUM_CH-1:0] riseEdge,
  output logic      [etm_pkg::NUM_CH-1:0] fallEdge
);
  import etm_pkg::*;

  logic [NUM_CH-1:0] syncFirst;
  logic [NUM_CH-1:0] syncSecond;
  logic [NUM_CH-1:0] pinLast;
  logic [1:0]        settle;
  logic              settled;

  assign settled = (settle == SETTLE_CYCLES);

  // Two-stage synchroniser, then a history stage for edge detection
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncFirst  <= '0;
      syncSecond <= '0;
      pinLast    <= '0;
    end
    else
    begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      pinLast    <= syncSecond;
    end
  end

  // Hold off edges until the pipeline holds real pin samples
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      settle <= 2'h0;
    else if (!settled)
      settle <= settle + 2'h1;
  end

  assign riseEdge = settled ? (syncSecond & ~pinLast) : '0;
  assign fallEdge = settled ? (~syncSecond & pinLast) : '0;

endmodule // etm_edge_sync

`default_nettype wire

// ==== etm_start_history.sv ====
// Sixteen-entry history of base timer values for one start edge source
`timescale 1ns/1ns
`default_nettype none

module etm_start_history
(
  input  wire logic                                                clk,
  input  wire logic                                                rstn,
  input  wire logic                                                push,
  input  wire logic [etm_pkg::BASE_W-1:0]                          stampIn,
  output logic      [etm_pkg::FIFO_DEPTH-1:0][etm_pkg::BASE_W-1:0] entry
);
  import etm_pkg::*;

  // Entry 0 is the newest start edge, older ones shift up and fall off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      entry <= '0;
    else if (push)
      entry <= {entry[FIFO_DEPTH-2:0], stampIn};
  end

endmodule // etm_start_history

`default_nettype wire

// ==== etm_checker.sv ====
// Bus answer checks for the edge timing block
`timescale 1ns/1ns
`default_nettype none
module etm_checker
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  import etm_pkg::*;
  // A fresh setup cycle seen by the slave
  wire logic setup = psel && !penable && !pready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Read setup to one address
  sequence rdSetup(a);
    setup && !pwrite && paddr == a;
  endsequence
  chk_ready_after_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_no_spurious_ready: assert property (!psel |=> !pready)
    else $error("pready without select");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  chk_unmapped_err: assert property (setup && paddr == 12'h024 |=> pslverr)
    else $error("unmapped address accepted");
  chk_mapped_no_err: assert property (setup && paddr[11:2] == 10'h0 |=> pready && !pslverr)
    else $error("mapped address refused");
  chk_hi_bit_reserved: assert property (rdSetup(12'h018) |=> prdata[31:7] == 25'h0)
    else $error("reserved pending bit set");
  chk_tally_width: assert property (rdSetup(12'h0E0) |=> prdata[31:8] == 24'h0)
    else $error("tally wider than a byte");
endmodule // etm_checker
bind etm_edge_timing etm_checker etm_checker_inst (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// ==== etm_pin_model.sv ====
// Pin side model that drives the channel levels
`timescale 1ns/1ns
`default_nettype none
module etm_pin_model
(
  input  wire logic                       clk,
  output logic      [etm_pkg::NUM_CH-1:0] pins
);
  import etm_pkg::*;
  // Pins start low so release of reset gives no edge
  initial pins = '0;
  // Change one channel at an edge, then let the synchroniser settle
  task automatic drive(input int ch, input logic lvl);
    @(posedge clk);
    pins[ch] <= lvl;
    repeat (3) @(posedge clk);
  endtask
endmodule // etm_pin_model
`default_nettype wire

// ==== tb_top.sv ====
// Register level test of the edge timing block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import etm_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, r, s1;
  wire logic [NUM_CH-1:0] pinIn;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  int n_mismatch = 0, checks_done = 0;
  // Free running clock
  always #5 clk = ~clk;
  etm_edge_timing etm_edge_timing_inst (.clk(clk), .rstn(rstn), .pinIn(pinIn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  etm_pin_model etm_pin_model_inst (.clk(clk), .pins(pinIn));
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  // Register-level bench; the 150 us bus cycle is the controller's own schedule
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd_v, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    xfer(1'b0, a, 32'h0, r, e);
    cmp($sformatf("reg %h", a), ex, r);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic pin(input int ch, input logic lvl);
    etm_pin_model_inst.drive(ch, lvl);
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h040, 32'h0);
    xfer(1'b0, 12'h024, 32'h0, r, e);
    cmp("unmapped error", 32'h1, {31'h0, e});
    pin(0, 1'b1);
    pin(0, 1'b0);
    rd(12'h0C0, 32'h0);
    wr(12'h000, 32'h1);
    wr(12'h040, 32'h0080);
    repeat (2)
    begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
    rd(12'h0C0, 32'h2);
    rd(12'h100, 32'h0);
    wr(12'h00C, 32'h1);
    rd(12'h01C, 32'h1);
    pin(0, 1'b1);
    rd(12'h01C, 32'h0);
    rd(12'h100, 32'h1);
    wr(12'h008, 32'h1);
    rd(12'h018, 32'h1);
    pin(8, 1'b1);
    pin(8, 1'b0);
    rd(12'h018, 32'h0);
    rd(12'h0E0, 32'h1);
    wr(12'h008, 32'hFF);
    rd(12'h008, 32'h7F);
    rd(12'h018, 32'h7F);
    wr(12'h084, 32'h1091);
    wr(12'h044, 32'h1080);
    pin(1, 1'b1);
    repeat (496) @(posedge clk);
    pin(1, 1'b0);
    repeat (496) @(posedge clk);
    pin(1, 1'b1);
    rd(12'h204, 32'h28);
    rd(12'h1C4, 32'h16);
    xfer(1'b0, 12'h144, 32'h0, s1, e);
    xfer(1'b0, 12'h184, 32'h0, r, e);
    cmp("stamp gap", 32'h14, r - s1);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
